// ===== verilog/ccm_pkg.sv
// constants, types and helpers shared by the cpu clock mode select block
package ccm_pkg;

    // strap codes of the eight clock generation modes
    localparam logic [2:0] CCM_STRAP_X4   = 3'h7;
    localparam logic [2:0] CCM_STRAP_X3   = 3'h6;
    localparam logic [2:0] CCM_STRAP_X2   = 3'h5;
    localparam logic [2:0] CCM_STRAP_X5   = 3'h4;
    localparam logic [2:0] CCM_STRAP_DIR  = 3'h3;
    localparam logic [2:0] CCM_STRAP_X1P5 = 3'h2;
    localparam logic [2:0] CCM_STRAP_DIV2 = 3'h1;
    localparam logic [2:0] CCM_STRAP_X2P5 = 3'h0;

    // where the cpu clock comes from
    typedef enum logic [1:0] {CCM_SRC_DIRECT, CCM_SRC_PRESCALE, CCM_SRC_PLL} ccm_src_t;

    // system clock and watchdog figures
    localparam int          CCM_CLK_PERIOD_NS  = 50;
    localparam int          CCM_WDOG_OVF_TICKS = 16;
    localparam int          CCM_WDOG_CNT_W     = 5;
    localparam int          CCM_FREE_HALF_CYC  = 3;
    localparam int          CCM_PER_W          = 8;
    localparam logic        CCM_CPU_CLK_RST    = 1'b0;

    // cpu clock edges per input period of the pll modes, i.e. twice the factor; direct and div2 give 2
    function automatic logic [3:0] ccm_edges(input logic [2:0] strap);
        logic [3:0] e;
        e = 4'h2;
        case (strap)
            CCM_STRAP_X4:   e = 4'h8;
            CCM_STRAP_X3:   e = 4'h6;
            CCM_STRAP_X2:   e = 4'h4;
            CCM_STRAP_X5:   e = 4'hA;
            CCM_STRAP_X1P5: e = 4'h3;
            CCM_STRAP_X2P5: e = 4'h5;
            default:        e = 4'h2;
        endcase
        return e;
    endfunction

    // source selected by a strap code
    function automatic ccm_src_t ccm_src(input logic [2:0] strap);
        ccm_src_t s;
        s = CCM_SRC_PLL;
        if (strap == CCM_STRAP_DIR)
            s = CCM_SRC_DIRECT;
        else if (strap == CCM_STRAP_DIV2)
            s = CCM_SRC_PRESCALE;
        return s;
    endfunction

endpackage

// ===== verilog/ccm_osc_wdog.sv
// oscillator watchdog: counts free pll ticks between input transitions
`timescale 1ns/100ps
`default_nettype none
module ccm_osc_wdog
    import ccm_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic enable_in,
    input  wire logic pll_tick_in,
    input  wire logic osc_edge_in,
    output var  logic fail_out
);
    logic [CCM_WDOG_CNT_W-1:0] cnt_ff;
    logic [CCM_WDOG_CNT_W-1:0] nxt_cnt;
    logic                      fail_ff;
    logic                      nxt_fail;

    // count ticks; any input transition restarts the count
    always_comb
    begin
        nxt_cnt  = cnt_ff;
        nxt_fail = fail_ff;
        if (!enable_in || osc_edge_in)
            nxt_cnt = '0;
        else if (pll_tick_in && !fail_ff)
        begin
            if (cnt_ff == CCM_WDOG_CNT_W'(CCM_WDOG_OVF_TICKS - 1))
                nxt_fail = 1'b1;
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // failure is sticky: only reset clears it
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_ff  <= '0;
            fail_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            fail_ff <= nxt_fail;
        end
    end

    assign fail_out = fail_ff;
endmodule
`default_nettype wire

// ===== verilog/ccm_clock_select.sv
// cpu clock mode select: strap latch, direct, prescaled and pll clock generation
`timescale 1ns/100ps
`default_nettype none
module ccm_clock_select
    import ccm_pkg::*;
#(
    parameter int PER_W         = CCM_PER_W,
    parameter int FREE_HALF_CYC = CCM_FREE_HALF_CYC
)
(
    input  wire logic       CLK_IN,
    input  wire logic       SYS_RST_IN,
    input  wire logic       OSC_IN,
    input  wire logic [2:0] CLK_MODE_STRAP_IN,
    input  wire logic       OSC_WDOG_DISABLE_IN,
    output var  logic       CPU_CLK_OUT,
    output var  logic       CPU_CLK_EDGE_OUT,
    output var  logic       PLL_ON_OUT,
    output var  logic       OSC_FAIL_IRQ_OUT,
    output var  logic [2:0] CLK_MODE_OUT
);
    import ccm_pkg::*;

    // the accumulator must hold the period plus up to ten edges per step
    if (PER_W < 5 || PER_W > 16 || FREE_HALF_CYC < 1 || FREE_HALF_CYC > 255)
    begin
        $error("ccm_clock_select: unsupported parameter values");
    end

    logic [2:0]       mode_ff;
    logic [2:0]       nxt_mode;
    logic             osc_ff;
    logic [PER_W-1:0] per_cnt_ff;
    logic [PER_W-1:0] nxt_per_cnt;
    logic [PER_W-1:0] per_ff;
    logic [PER_W-1:0] nxt_per;
    logic [PER_W:0]   acc_ff;
    logic [PER_W:0]   nxt_acc;
    logic             sync_ff;
    logic             nxt_sync;
    logic             osc_vld_ff;
    logic             meas_ff;
    logic             nxt_meas;
    logic [7:0]       free_cnt_ff;
    logic [7:0]       nxt_free_cnt;
    logic             free_clk_ff;
    logic             nxt_free_clk;
    logic             cpu_clk_ff;
    logic             nxt_cpu_clk;
    logic             edge_ff;
    logic             pll_on_ff;
    logic             nxt_pll_on;
    logic             irq_ff;
    logic             fail_seen_ff;
    logic             wdog_fail;
    logic             osc_edge;
    logic             osc_rise;
    logic             pll_tick;
    logic             pll_toggle;
    logic [PER_W:0]   acc_sum;
    ccm_src_t         src;
    logic [3:0]       edges;
    logic             wdog_en;

    // strap latch: follows the pins only while reset is held, so it needs no reset
    // of its own; the clock must run during reset for the capture to happen
    always_comb
    begin
        nxt_mode = mode_ff;
        if (SYS_RST_IN)
            nxt_mode = CLK_MODE_STRAP_IN;
    end

    always_ff @(posedge CLK_IN)
    begin
        mode_ff <= nxt_mode;
    end

    // mode decode from the latched straps
    always_comb
    begin
        src      = ccm_src(mode_ff);
        edges    = ccm_edges(mode_ff);
        // the first sample after reset has no history, so it makes no edge
        osc_edge = osc_vld_ff && (OSC_IN != osc_ff);
        osc_rise = osc_vld_ff && OSC_IN && !osc_ff;
        // watchdog only guards the non-pll sources; enabled unless disabled
        wdog_en  = (src != CCM_SRC_PLL) && !OSC_WDOG_DISABLE_IN;
    end

    // pll power: on for multiply modes, or free-running to clock the watchdog
    always_comb
    begin
        nxt_pll_on = (src == CCM_SRC_PLL) || !OSC_WDOG_DISABLE_IN || fail_seen_ff;
        if (src == CCM_SRC_DIRECT && OSC_WDOG_DISABLE_IN && !fail_seen_ff)
            nxt_pll_on = 1'b0;
    end

    // free-running pll oscillator model; stops while the pll is off
    always_comb
    begin
        nxt_free_cnt = free_cnt_ff;
        nxt_free_clk = free_clk_ff;
        if (!pll_on_ff)
        begin
            nxt_free_cnt = '0;
            nxt_free_clk = 1'b0;
        end
        else if (free_cnt_ff == 8'(FREE_HALF_CYC - 1))
        begin
            nxt_free_cnt = '0;
            nxt_free_clk = !free_clk_ff;
        end
        else
            nxt_free_cnt = free_cnt_ff + 8'h01;
        pll_tick = nxt_free_clk && !free_clk_ff;
    end

    // input period measurement and the edge accumulator of the pll modes;
    // resync only clears the phase remainder, so no phase ever jumps
    always_comb
    begin
        nxt_per_cnt = per_cnt_ff;
        nxt_per     = per_ff;
        nxt_acc     = acc_ff;
        nxt_sync    = sync_ff;
        nxt_meas    = meas_ff;
        pll_toggle  = 1'b0;
        acc_sum     = acc_ff + (PER_W+1)'(edges);
        if (per_cnt_ff != '1)
            nxt_per_cnt = per_cnt_ff + 1'b1;                      // saturates on a dead input
        if (per_ff != '0 && acc_sum >= {1'b0, per_ff})
        begin
            nxt_acc    = acc_sum - {1'b0, per_ff};
            pll_toggle = 1'b1;
        end
        else if (per_ff != '0)
            nxt_acc = acc_sum;
        if (osc_rise && !meas_ff)
        begin
            // the first rise after reset only starts the count: the time
            // since release is no input period
            nxt_per_cnt = '0;
            nxt_meas    = 1'b1;
        end
        else if (osc_rise)
        begin
            nxt_per     = per_cnt_ff + 1'b1;
            nxt_per_cnt = '0;
            // odd edge counts (x1.5, x2.5) realign only every second input period
            nxt_sync    = edges[0] ? !sync_ff : 1'b0;
            if (!edges[0] || sync_ff)
                nxt_acc = '0;
        end
    end

    // cpu clock source selection
    always_comb
    begin
        nxt_cpu_clk = cpu_clk_ff;
        if (fail_seen_ff)
            nxt_cpu_clk = free_clk_ff;
        else
            unique case (src)
                CCM_SRC_DIRECT:   nxt_cpu_clk = OSC_IN;
                CCM_SRC_PRESCALE: nxt_cpu_clk = osc_rise ? !cpu_clk_ff : cpu_clk_ff;
                CCM_SRC_PLL:      nxt_cpu_clk = pll_toggle ? !cpu_clk_ff : cpu_clk_ff;
            endcase
    end

    // all clocked state except the strap latch
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            osc_ff       <= 1'b0;
            per_cnt_ff   <= '0;
            per_ff       <= '0;
            acc_ff       <= '0;
            sync_ff      <= 1'b0;
            osc_vld_ff   <= 1'b0;
            meas_ff      <= 1'b0;
            free_cnt_ff  <= '0;
            free_clk_ff  <= 1'b0;
            cpu_clk_ff   <= CCM_CPU_CLK_RST;
            edge_ff      <= 1'b0;
            pll_on_ff    <= 1'b0;
            irq_ff       <= 1'b0;
            fail_seen_ff <= 1'b0;
        end
        else
        begin
            osc_ff       <= OSC_IN;
            per_cnt_ff   <= nxt_per_cnt;
            per_ff       <= nxt_per;
            acc_ff       <= nxt_acc;
            sync_ff      <= nxt_sync;
            osc_vld_ff   <= 1'b1;
            meas_ff      <= nxt_meas;
            free_cnt_ff  <= nxt_free_cnt;
            free_clk_ff  <= nxt_free_clk;
            cpu_clk_ff   <= nxt_cpu_clk;
            edge_ff      <= nxt_cpu_clk != cpu_clk_ff;
            pll_on_ff    <= nxt_pll_on;
            irq_ff       <= wdog_fail && !fail_seen_ff;
            fail_seen_ff <= wdog_fail;
        end
    end

    // watchdog on the free pll ticks
    ccm_osc_wdog u_wdog
    (
        .clk_in      (CLK_IN),
        .rst_in      (SYS_RST_IN),
        .enable_in   (wdog_en),
        .pll_tick_in (pll_tick),
        .osc_edge_in (osc_edge),
        .fail_out    (wdog_fail)
    );

    assign CPU_CLK_OUT      = cpu_clk_ff;
    assign CPU_CLK_EDGE_OUT = edge_ff;
    assign PLL_ON_OUT       = pll_on_ff;
    assign OSC_FAIL_IRQ_OUT = irq_ff;
    assign CLK_MODE_OUT     = mode_ff;
endmodule
`default_nettype wire

// ===== tb/ccm_clock_select_properties.sv
// port checker for the cpu clock mode select block
`timescale 1ns/100ps
`default_nettype none
module ccm_clock_select_properties
    import ccm_pkg::*;
#(
    parameter int FREE_HALF_CYC = CCM_FREE_HALF_CYC
)
(
    input wire logic       CLK_IN,
    input wire logic       SYS_RST_IN,
    input wire logic       OSC_IN,
    input wire logic [2:0] CLK_MODE_STRAP_IN,
    input wire logic       OSC_WDOG_DISABLE_IN,
    input wire logic       CPU_CLK_OUT,
    input wire logic       CPU_CLK_EDGE_OUT,
    input wire logic       PLL_ON_OUT,
    input wire logic       OSC_FAIL_IRQ_OUT,
    input wire logic [2:0] CLK_MODE_OUT
);
    localparam int HMAX = FREE_HALF_CYC + 2;
    localparam int TICK = 2 * FREE_HALF_CYC;
    logic [1:0] run_ff;
    logic       osc_q_ff;
    logic       rise_ff;
    logic       clk_q_ff;
    logic       dis_q_ff;
    logic       fail_ff;
    logic [8:0] stuck_ff;
    logic       wd_mode;
    logic       div2;
    // watchdog only guards the modes that run straight off the input
    assign div2    = CLK_MODE_OUT == CCM_STRAP_DIV2;
    assign wd_mode = div2 || CLK_MODE_OUT == CCM_STRAP_DIR;
    // history of the ports; the first edges after reset are skipped via run_ff
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
        if (SYS_RST_IN)
        begin
            run_ff    <= 2'h0;
            osc_q_ff  <= 1'b0;
            rise_ff   <= 1'b0;
            clk_q_ff  <= 1'b0;
            dis_q_ff  <= 1'b0;
            fail_ff   <= 1'b0;
            stuck_ff  <= 9'h000;
        end
        else
        begin
            run_ff    <= (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
            osc_q_ff  <= OSC_IN;
            rise_ff   <= OSC_IN && !osc_q_ff;
            clk_q_ff  <= CPU_CLK_OUT;
            dis_q_ff  <= OSC_WDOG_DISABLE_IN;
            fail_ff   <= fail_ff | OSC_FAIL_IRQ_OUT;
            stuck_ff  <= (OSC_IN != osc_q_ff || OSC_WDOG_DISABLE_IN) ? 9'h000 : stuck_ff + 9'h001;
        end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    property p_strap_take;
        $fell(SYS_RST_IN) |-> CLK_MODE_OUT == $past(CLK_MODE_STRAP_IN);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("mode not from straps");
    property p_mode_hold;
        run_ff != 2'h0 |-> $stable(CLK_MODE_OUT);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    property p_direct;
        run_ff == 2'h3 && CLK_MODE_OUT == CCM_STRAP_DIR && !fail_ff && !OSC_FAIL_IRQ_OUT
            |-> CPU_CLK_OUT == osc_q_ff;
    endproperty
    a_direct: assert property (p_direct) else $error("direct clock wrong");
    property p_div2;
        run_ff == 2'h3 && div2 && !fail_ff && !OSC_FAIL_IRQ_OUT
            |-> (CPU_CLK_OUT != clk_q_ff) == rise_ff;
    endproperty
    a_div2: assert property (p_div2) else $error("prescaled clock wrong");
    property p_pll_on;
        run_ff == 2'h3 |-> PLL_ON_OUT == (fail_ff || OSC_FAIL_IRQ_OUT || !dis_q_ff || !wd_mode);
    endproperty
    a_pll_on: assert property (p_pll_on) else $error("pll power wrong");
    property p_edge;
        run_ff == 2'h3 |-> CPU_CLK_EDGE_OUT == (CPU_CLK_OUT != clk_q_ff);
    endproperty
    a_edge: assert property (p_edge) else $error("edge pulse wrong");
    property p_irq_early;
        OSC_FAIL_IRQ_OUT |-> wd_mode && !fail_ff && stuck_ff >= 15 * TICK;
    endproperty
    a_irq_early: assert property (p_irq_early) else $error("early failover");
    property p_irq_late;
        run_ff == 2'h3 && wd_mode && stuck_ff >= 16 * TICK + 4 |-> fail_ff;
    endproperty
    a_irq_late: assert property (p_irq_late) else $error("missed failover");
    property p_sticky;
        fail_ff |-> !OSC_FAIL_IRQ_OUT && PLL_ON_OUT ##[0:HMAX] CPU_CLK_EDGE_OUT;
    endproperty
    a_sticky: assert property (p_sticky) else $error("failover not held");
endmodule
bind ccm_clock_select ccm_clock_select_properties #(.FREE_HALF_CYC(FREE_HALF_CYC)) u_chk (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .OSC_IN(OSC_IN),
    .CLK_MODE_STRAP_IN(CLK_MODE_STRAP_IN), .OSC_WDOG_DISABLE_IN(OSC_WDOG_DISABLE_IN),
    .CPU_CLK_OUT(CPU_CLK_OUT), .CPU_CLK_EDGE_OUT(CPU_CLK_EDGE_OUT), .PLL_ON_OUT(PLL_ON_OUT),
    .OSC_FAIL_IRQ_OUT(OSC_FAIL_IRQ_OUT), .CLK_MODE_OUT(CLK_MODE_OUT));
`default_nettype wire

// ===== tb/ccm_osc_src.sv
// behavioural oscillator source at the block's input
`timescale 1ns/100ps
`default_nettype none
module ccm_osc_src
(
    input  wire logic       clk_in,
    input  wire logic       run_in,
    input  wire logic [7:0] hi_in,
    input  wire logic [7:0] lo_in,
    output var  logic       osc_out
);
    logic [7:0] cnt;
    initial
    begin
        osc_out = 1'b0;
        cnt     = 8'h00;
    end
    // a dead crystal stands still at its last level, which the watchdog must catch
    always @(negedge clk_in)
        if (run_in)
        begin
            cnt = cnt + 8'h01;
            if (cnt >= (osc_out ? hi_in : lo_in))
            begin
                osc_out = ~osc_out;
                cnt     = 8'h00;
            end
        end
endmodule
`default_nettype wire

// ===== tb/tb_cpu_clock_mode_select.sv
// self-checking bench for the cpu clock mode select block
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_clock_mode_select;
    import ccm_pkg::*;
    localparam int TICK = 2 * CCM_FREE_HALF_CYC;
    logic       clk, rst, dis, run, osc, cpu, edg, pll, irq;
    logic [2:0] strap;
    logic [2:0] mode;
    logic [7:0] hi;
    logic [7:0] lo;
    int         miscompares, num_checks, cyc, h, l, n;
    byte        epp [8] = '{5, 1, 3, 2, 10, 4, 6, 8};
    always #(CCM_CLK_PERIOD_NS / 2) clk = ~clk;
    ccm_osc_src u_osc (.clk_in(clk), .run_in(run), .hi_in(hi), .lo_in(lo), .osc_out(osc));
    ccm_clock_select dut (.CLK_IN(clk), .SYS_RST_IN(rst), .OSC_IN(osc),
        .CLK_MODE_STRAP_IN(strap), .OSC_WDOG_DISABLE_IN(dis), .CPU_CLK_OUT(cpu),
        .CPU_CLK_EDGE_OUT(edg), .PLL_ON_OUT(pll), .OSC_FAIL_IRQ_OUT(irq), .CLK_MODE_OUT(mode));
    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // straps move right after release so a latch that keeps following them shows
    task automatic boot(input logic [2:0] s, input logic d);
        @(negedge clk);
        rst   = 1'b1;
        strap = s;
        dis   = d;
        repeat (20) @(negedge clk);
        rst   = 1'b0;
        @(negedge clk);
        strap = ~s;
        repeat (30) @(negedge clk);
        chk(mode === s, "mode code");
    endtask
    task automatic span(input logic v, output int c);
        c = 0;
        while (cpu === v && c < 400)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic phase();
        span(1'b1, n);
        span(1'b0, n);
        span(1'b1, h);
        span(1'b0, l);
    endtask
    // every code, input period 24 cycles, four periods counted
    task automatic t_modes();
        for (int c = 0; c < 8; c++)
        begin
            boot(3'(c), 1'b1);
            // the pll counts only from the second input rise after release
            repeat (48) @(negedge clk);
            n = 0;
            repeat (96)
            begin
                @(negedge clk);
                n += int'(edg === 1'b1);
            end
            chk(n >= 4 * epp[c] - 1 && n <= 4 * epp[c] + 1, "edge count");
            chk(pll === (c != 3 && c != 1), "pll power");
        end
    endtask
    // lopsided input duty shows which phases follow the input
    task automatic t_duty();
        hi = 8'h03;
        lo = 8'h09;
        boot(CCM_STRAP_DIR, 1'b1);
        phase();
        chk(h == 3 && l == 9, "direct phases");
        boot(CCM_STRAP_DIV2, 1'b1);
        phase();
        chk(h == 12 && l == 12, "prescaled phases");
    endtask
    // stop the input in one watchdog-guarded mode and time the failover
    task automatic t_fail(input logic [2:0] s);
        boot(s, 1'b0);
        chk(pll === 1'b1, "pll for watchdog");
        run = 1'b0;
        n   = 0;
        while (irq !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        chk(n >= 14 * TICK && n <= 16 * TICK + 4, "failover time");
        @(negedge clk);
        chk(irq === 1'b0, "irq width");
        run = 1'b1;
        phase();
        chk(h == CCM_FREE_HALF_CYC && l == CCM_FREE_HALF_CYC, "free clock");
    endtask
    task automatic t_wdog();
        hi = 8'h06;
        lo = 8'h06;
        t_fail(CCM_STRAP_DIR);
        t_fail(CCM_STRAP_DIV2);
        boot(CCM_STRAP_DIR, 1'b1);
        run = 1'b0;
        n   = 0;
        repeat (200)
        begin
            @(negedge clk);
            n += int'(irq === 1'b1);
        end
        chk(n == 0 && pll === 1'b0, "watchdog off");
        run = 1'b1;
        phase();
        chk(h == 6 && l == 6, "input clock back");
    endtask
    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        dis = 1'b1;
        run = 1'b1;
        strap = 3'h7;
        hi = 8'h0C;
        lo = 8'h0C;
        t_modes();
        t_duty();
        t_wdog();
        results();
    end
endmodule
`default_nettype wire
